// ==== verilog/sbk_pkg.sv ====
// package: addresses, reset values and field layout of the bank-1 config block
package sbk_pkg;

  // ===========================================================================
  // register addresses (byte offsets on the serial register port)
  localparam logic [7:0] SBK_ADDR_FILTER     = 8'h13;
  localparam logic [7:0] SBK_ADDR_ST_X       = 8'h5F;
  localparam logic [7:0] SBK_ADDR_ST_Y       = 8'h60;
  localparam logic [7:0] SBK_ADDR_ST_Z       = 8'h61;
  localparam logic [7:0] SBK_ADDR_TS_LOW     = 8'h62;
  localparam logic [7:0] SBK_ADDR_TS_MID     = 8'h63;
  localparam logic [7:0] SBK_ADDR_TS_HIGH    = 8'h64;
  localparam logic [7:0] SBK_ADDR_BUS_WIRE   = 8'h7A;
  localparam logic [7:0] SBK_ADDR_SHARED_PIN = 8'h7B;
  localparam logic [7:0] SBK_ADDR_I3C_FEAT   = 8'h7C;
  localparam logic [7:0] SBK_ADDR_BANK_SEL   = 8'h76;

  // ===========================================================================
  // bank selection
  localparam logic [2:0] SBK_BANK_THIS       = 3'h1;
  localparam logic [2:0] SBK_BANK_RESET      = 3'h0;
  localparam logic [7:0] SBK_BANK_SEL_MASK   = 8'h07;

  // ===========================================================================
  // reset values as printed
  localparam logic [7:0] SBK_RST_FILTER      = 8'h11;
  localparam logic [7:0] SBK_RST_TS          = 8'h00;
  localparam logic [7:0] SBK_RST_BUS_WIRE    = 8'h03;
  localparam logic [7:0] SBK_RST_SHARED_PIN  = 8'h20;
  localparam logic [7:0] SBK_RST_I3C_FEAT    = 8'h5F;
  localparam logic [7:0] SBK_RST_SELFTEST    = 8'h00;

  // ===========================================================================
  // implemented-bit masks; everything else is reserved
  localparam logic [7:0] SBK_MASK_FILTER     = 8'h7F;
  localparam logic [7:0] SBK_MASK_SELFTEST   = 8'hFF;
  localparam logic [7:0] SBK_MASK_BUS_WIRE   = 8'h42;
  localparam logic [7:0] SBK_MASK_SHARED_PIN = 8'h06;
  localparam logic [7:0] SBK_MASK_I3C_FEAT   = 8'h9F;
  localparam logic [7:0] SBK_MASK_TS_HIGH    = 8'h0F;

  // ===========================================================================
  // field positions
  localparam int SBK_NOTCH_MSB   = 6;
  localparam int SBK_NOTCH_LSB   = 4;
  localparam int SBK_HPF_MSB     = 3;
  localparam int SBK_HPF_LSB     = 1;
  localparam int SBK_HPF_ORD_BIT = 0;
  localparam int SBK_BUS_MODE_BIT = 6;
  localparam int SBK_WIRE_BIT    = 1;
  localparam int SBK_PINFN_MSB   = 2;
  localparam int SBK_PINFN_LSB   = 1;
  localparam int SBK_ASYNC_DIS_BIT = 7;
  localparam int SBK_I3C_EN_BIT  = 4;
  localparam int SBK_IBI_PL_BIT  = 3;
  localparam int SBK_IBI_EN_BIT  = 2;
  localparam int SBK_DDR_EN_BIT  = 1;
  localparam int SBK_SDR_EN_BIT  = 0;
  localparam int SBK_TS_WIDTH    = 20;

  // ===========================================================================
  // shared-pin function codes
  localparam logic [1:0] SBK_PINFN_SECOND_INTERRUPT_OUTPUT  = 2'h0;
  localparam logic [1:0] SBK_PINFN_FRAME_SYNC_INPUT = 2'h1;

  // ===========================================================================
  // self-test preload sequencer, gray along the path
  typedef enum logic [1:0] {
    SBK_PRE_IDLE = 2'b00,
    SBK_PRE_LOAD = 2'b01,
    SBK_PRE_DONE = 2'b11
  } sbk_pre_state_t;

endpackage : sbk_pkg

// ==== verilog/sbk_cfg_reg.sv ====
// one 8-bit configuration register with reserved-bit masking and preload
`timescale 1ns/1ps
`default_nettype none
module sbk_cfg_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] FIELD_MASK  = 8'hFF
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  input  wire logic       load_en,
  input  wire logic [7:0] load_data,
  output var  logic [7:0] q
);

  // ===========================================================================
  // storage; reserved bits never store, so they always read zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= RESET_VALUE & FIELD_MASK;
    end else if (clk_en) begin
      if (load_en) begin
        q <= load_data & FIELD_MASK;
      end else if (wr_en) begin
        q <= wdata & FIELD_MASK;
      end
    end
  end

endmodule : sbk_cfg_reg
`default_nettype wire

// ==== verilog/sbk_bank1_regs.sv ====
// bank-1 configuration registers: filters, self-test, timestamp, host i/f
`timescale 1ns/1ps
`default_nettype none
module sbk_bank1_regs
  import sbk_pkg::*;
#(
  parameter int TS_WIDTH = SBK_TS_WIDTH
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                clk_en,
  // register port from the serial engine
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_rd,
  output var  logic [7:0]          reg_rdata,
  output var  logic [2:0]          bank_select,
  // factory trim for the self-test registers
  input  wire logic [7:0]          trim_selftest_x,
  input  wire logic [7:0]          trim_selftest_y,
  input  wire logic [7:0]          trim_selftest_z,
  // timestamp
  input  wire logic [TS_WIDTH-1:0] timestamp_count,
  input  wire logic                timestamp_capture_strobe,
  // gyro filter controls
  output var  logic [2:0]          notch_bandwidth_select,
  output var  logic [2:0]          highpass_cutoff_select,
  output var  logic                highpass_order_select,
  // host interface controls
  output var  logic                i3c_only_bus,
  output var  logic                host_spi_wire_select,
  output var  logic [1:0]          shared_pin_function,
  // shared pin
  input  wire logic                second_interrupt_output,
  input  wire logic                shared_pin_in,
  output var  logic                shared_pin_out,
  output var  logic                shared_pin_oe,
  output var  logic                frame_sync_input,
  // i3c target gating
  input  wire logic                ccc_enter_async0,
  input  wire logic                ccc_exit_async0,
  input  wire logic                ibi_request_in,
  input  wire logic                ibi_payload_in,
  input  wire logic                ddr_request_in,
  input  wire logic                sdr_request_in,
  output var  logic                i3c_target_active,
  output var  logic                async_mode0_active,
  output var  logic                ibi_request_out,
  output var  logic                ibi_payload_attach,
  output var  logic                ddr_accept,
  output var  logic                sdr_accept
);

  // ===========================================================================
  // address decode
  logic       in_bank;
  logic       wr_filter;
  logic       wr_st_x;
  logic       wr_st_y;
  logic       wr_st_z;
  logic       wr_bus_wire;
  logic       wr_shared_pin;
  logic       wr_i3c_feat;
  logic       wr_bank_sel;
  logic       preload_en;
  logic [7:0] q_filter;
  logic [7:0] q_st_x;
  logic [7:0] q_st_y;
  logic [7:0] q_st_z;
  logic [7:0] q_bus_wire;
  logic [7:0] q_shared_pin;
  logic [7:0] q_i3c_feat;
  logic [TS_WIDTH-1:0] ts_capture;
  logic [7:0] next_rdata;
  sbk_pre_state_t pre_state;
  sbk_pre_state_t next_pre_state;

  // bank registers only answer while bank 1 is selected
  assign in_bank       = (bank_select == SBK_BANK_THIS);
  assign wr_filter     = reg_wr && in_bank && (reg_addr == SBK_ADDR_FILTER);
  assign wr_st_x       = reg_wr && in_bank && (reg_addr == SBK_ADDR_ST_X);
  assign wr_st_y       = reg_wr && in_bank && (reg_addr == SBK_ADDR_ST_Y);
  assign wr_st_z       = reg_wr && in_bank && (reg_addr == SBK_ADDR_ST_Z);
  assign wr_bus_wire   = reg_wr && in_bank
                         && (reg_addr == SBK_ADDR_BUS_WIRE);
  assign wr_shared_pin = reg_wr && in_bank
                         && (reg_addr == SBK_ADDR_SHARED_PIN);
  assign wr_i3c_feat   = reg_wr && in_bank
                         && (reg_addr == SBK_ADDR_I3C_FEAT);
  // page select is visible from every bank
  assign wr_bank_sel   = reg_wr && (reg_addr == SBK_ADDR_BANK_SEL);

  // ===========================================================================
  // page select register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bank_select <= SBK_BANK_RESET;
    end else if (clk_en && wr_bank_sel) begin
      bank_select <= reg_wdata[2:0];
    end
  end

  // ===========================================================================
  // self-test preload: trim inputs are sampled after reset release, never
  // under the asynchronous reset itself
  always_comb begin
    next_pre_state = pre_state;
    case (pre_state)
      SBK_PRE_IDLE: next_pre_state = SBK_PRE_LOAD;
      SBK_PRE_LOAD: next_pre_state = SBK_PRE_DONE;
      SBK_PRE_DONE: next_pre_state = SBK_PRE_DONE;
      default:      next_pre_state = SBK_PRE_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_state <= SBK_PRE_IDLE;
    end else if (clk_en) begin
      pre_state <= next_pre_state;
    end
  end

  assign preload_en = (pre_state == SBK_PRE_LOAD);

  // ===========================================================================
  // configuration registers; masks keep reserved bits at zero
  sbk_cfg_reg #(
    .RESET_VALUE (SBK_RST_FILTER),
    .FIELD_MASK  (SBK_MASK_FILTER)
  ) u_filter (
    .clk       (clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .wr_en     (wr_filter),
    .wdata     (reg_wdata),
    .load_en   (1'b0),
    .load_data (8'h00),
    .q         (q_filter)
  );

  sbk_cfg_reg #(
    .RESET_VALUE (SBK_RST_SELFTEST),
    .FIELD_MASK  (SBK_MASK_SELFTEST)
  ) u_st_x (
    .clk       (clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .wr_en     (wr_st_x),
    .wdata     (reg_wdata),
    .load_en   (preload_en),
    .load_data (trim_selftest_x),
    .q         (q_st_x)
  );

  sbk_cfg_reg #(
    .RESET_VALUE (SBK_RST_SELFTEST),
    .FIELD_MASK  (SBK_MASK_SELFTEST)
  ) u_st_y (
    .clk       (clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .wr_en     (wr_st_y),
    .wdata     (reg_wdata),
    .load_en   (preload_en),
    .load_data (trim_selftest_y),
    .q         (q_st_y)
  );

  sbk_cfg_reg #(
    .RESET_VALUE (SBK_RST_SELFTEST),
    .FIELD_MASK  (SBK_MASK_SELFTEST)
  ) u_st_z (
    .clk       (clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .wr_en     (wr_st_z),
    .wdata     (reg_wdata),
    .load_en   (preload_en),
    .load_data (trim_selftest_z),
    .q         (q_st_z)
  );

  sbk_cfg_reg #(
    .RESET_VALUE (SBK_RST_BUS_WIRE),
    .FIELD_MASK  (SBK_MASK_BUS_WIRE)
  ) u_bus_wire (
    .clk       (clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .wr_en     (wr_bus_wire),
    .wdata     (reg_wdata),
    .load_en   (1'b0),
    .load_data (8'h00),
    .q         (q_bus_wire)
  );

  sbk_cfg_reg #(
    .RESET_VALUE (SBK_RST_SHARED_PIN),
    .FIELD_MASK  (SBK_MASK_SHARED_PIN)
  ) u_shared_pin (
    .clk       (clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .wr_en     (wr_shared_pin),
    .wdata     (reg_wdata),
    .load_en   (1'b0),
    .load_data (8'h00),
    .q         (q_shared_pin)
  );

  sbk_cfg_reg #(
    .RESET_VALUE (SBK_RST_I3C_FEAT),
    .FIELD_MASK  (SBK_MASK_I3C_FEAT)
  ) u_i3c_feat (
    .clk       (clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .wr_en     (wr_i3c_feat),
    .wdata     (reg_wdata),
    .load_en   (1'b0),
    .load_data (8'h00),
    .q         (q_i3c_feat)
  );

  // ===========================================================================
  // field outputs come straight from the register flops
  assign notch_bandwidth_select =
    q_filter[SBK_NOTCH_MSB:SBK_NOTCH_LSB];
  assign highpass_cutoff_select =
    q_filter[SBK_HPF_MSB:SBK_HPF_LSB];
  assign highpass_order_select  = q_filter[SBK_HPF_ORD_BIT];
  assign i3c_only_bus           = q_bus_wire[SBK_BUS_MODE_BIT];
  assign host_spi_wire_select   = q_bus_wire[SBK_WIRE_BIT];
  assign shared_pin_function    =
    q_shared_pin[SBK_PINFN_MSB:SBK_PINFN_LSB];

  // ===========================================================================
  // timestamp capture; the counter is sampled whole in one edge so the
  // three bytes always belong to the same instant
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ts_capture <= '0;
    end else if (clk_en && timestamp_capture_strobe) begin
      ts_capture <= timestamp_count;
    end
  end

  // ===========================================================================
  // shared pin routing; reserved codes leave the pin undriven and idle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shared_pin_out   <= 1'b0;
      shared_pin_oe    <= 1'b0;
      frame_sync_input <= 1'b0;
    end else if (clk_en) begin
      shared_pin_oe    <= (shared_pin_function == SBK_PINFN_SECOND_INTERRUPT_OUTPUT);
      shared_pin_out   <= (shared_pin_function == SBK_PINFN_SECOND_INTERRUPT_OUTPUT)
                          && second_interrupt_output;
      frame_sync_input <= (shared_pin_function == SBK_PINFN_FRAME_SYNC_INPUT)
                          && shared_pin_in;
    end
  end

  // ===========================================================================
  // i3c target feature gating
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      i3c_target_active  <= 1'b0;
      ibi_request_out    <= 1'b0;
      ibi_payload_attach <= 1'b0;
      ddr_accept         <= 1'b0;
      sdr_accept         <= 1'b0;
    end else if (clk_en) begin
      i3c_target_active  <= q_i3c_feat[SBK_I3C_EN_BIT];
      ibi_request_out    <= q_i3c_feat[SBK_I3C_EN_BIT]
                            && q_i3c_feat[SBK_IBI_EN_BIT]
                            && ibi_request_in;
      ibi_payload_attach <= q_i3c_feat[SBK_I3C_EN_BIT]
                            && q_i3c_feat[SBK_IBI_EN_BIT]
                            && q_i3c_feat[SBK_IBI_PL_BIT]
                            && ibi_payload_in;
      ddr_accept         <= q_i3c_feat[SBK_I3C_EN_BIT]
                            && q_i3c_feat[SBK_DDR_EN_BIT]
                            && ddr_request_in;
      sdr_accept         <= q_i3c_feat[SBK_I3C_EN_BIT]
                            && q_i3c_feat[SBK_SDR_EN_BIT]
                            && sdr_request_in;
    end
  end

  // async mode 0: entry needs an enabled target and the feature not disabled;
  // disabling either drops the mode so no stale timing control lingers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      async_mode0_active <= 1'b0;
    end else if (clk_en) begin
      if (!q_i3c_feat[SBK_I3C_EN_BIT] || q_i3c_feat[SBK_ASYNC_DIS_BIT]) begin
        async_mode0_active <= 1'b0;
      end else if (ccc_enter_async0) begin
        async_mode0_active <= 1'b1;
      end else if (ccc_exit_async0) begin
        async_mode0_active <= 1'b0;
      end
    end
  end

  // ===========================================================================
  // read mux; unmapped or out-of-bank addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == SBK_ADDR_BANK_SEL) begin
      next_rdata = {5'h00, bank_select};
    end else if (in_bank) begin
      case (reg_addr)
        SBK_ADDR_FILTER:     next_rdata = q_filter;
        SBK_ADDR_ST_X:       next_rdata = q_st_x;
        SBK_ADDR_ST_Y:       next_rdata = q_st_y;
        SBK_ADDR_ST_Z:       next_rdata = q_st_z;
        SBK_ADDR_TS_LOW:     next_rdata = ts_capture[7:0];
        SBK_ADDR_TS_MID:     next_rdata = ts_capture[15:8];
        SBK_ADDR_TS_HIGH:    next_rdata = {4'h0, ts_capture[19:16]};
        SBK_ADDR_BUS_WIRE:   next_rdata = q_bus_wire;
        SBK_ADDR_SHARED_PIN: next_rdata = q_shared_pin;
        SBK_ADDR_I3C_FEAT:   next_rdata = q_i3c_feat;
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : sbk_bank1_regs
`default_nettype wire

// ==== verif/sbk_bank1_asserts.sv ====
// checker for the bank-1 configuration register block
`timescale 1ns/1ps
`default_nettype none
module sbk_bank1_asserts (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] bank_select,
  input wire logic [2:0] notch_bandwidth_select,
  input wire logic [2:0] highpass_cutoff_select,
  input wire logic       highpass_order_select,
  input wire logic       i3c_only_bus,
  input wire logic       host_spi_wire_select,
  input wire logic [1:0] shared_pin_function,
  input wire logic       shared_pin_in,
  input wire logic       shared_pin_oe,
  input wire logic       frame_sync_input,
  input wire logic       ccc_enter_async0,
  input wire logic       ibi_request_in,
  input wire logic       ibi_payload_in,
  input wire logic       ddr_request_in,
  input wire logic       sdr_request_in,
  input wire logic       i3c_target_active,
  input wire logic       async_mode0_active,
  input wire logic       ibi_request_out,
  input wire logic       ibi_payload_attach,
  input wire logic       ddr_accept,
  input wire logic       sdr_accept
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // a write that bank 1 takes
  wire wr1 = clk_en && reg_wr && bank_select == 3'h1;
  // ========
  // register port
  bank_write_a: assert property (
    clk_en && reg_wr && reg_addr == 8'h76 |=> bank_select == $past(reg_wdata[2:0]))
    else $error("bank select not updated");
  filter_write_a: assert property (
    wr1 && reg_addr == 8'h13 |=> {notch_bandwidth_select, highpass_cutoff_select,
    highpass_order_select} == $past(reg_wdata[6:0])) else $error("filter fields wrong");
  wire_write_a: assert property (
    wr1 && reg_addr == 8'h7A |=> {i3c_only_bus, host_spi_wire_select} ==
    {$past(reg_wdata[6]), $past(reg_wdata[1])}) else $error("bus wire bits wrong");
  offbank_read_a: assert property (
    clk_en && reg_rd && bank_select != 3'h1 && reg_addr != 8'h76 |=> reg_rdata == 8'h00)
    else $error("read outside bank 1 not zero");
  rdata_hold_a: assert property (!(clk_en && reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  // ========
  // shared pin and i3c gating
  // the first edge after reset still shows reset values, so skip it
  pin_route_a: assert property ($past(clk_en) && $past(nrst) |->
    shared_pin_oe == ($past(shared_pin_function) == 2'h0) && frame_sync_input ==
    ($past(shared_pin_function) == 2'h1 && $past(shared_pin_in))) else $error("pin route");
  gate_target_a: assert property (!i3c_target_active |-> !(ibi_request_out ||
    ddr_accept || sdr_accept || ibi_payload_attach || async_mode0_active))
    else $error("i3c feature active while target off");
  req_follow_a: assert property ($past(clk_en) |->
    (!ibi_request_out || $past(ibi_request_in))
    && (!ibi_payload_attach || $past(ibi_payload_in))
    && (!ddr_accept || $past(ddr_request_in)) && (!sdr_accept || $past(sdr_request_in)))
    else $error("gated output without its request");
  async_rise_a: assert property (
    $rose(async_mode0_active) |-> $past(ccc_enter_async0)) else $error("async without ccc");
  cover property (wr1 && reg_addr == 8'h7C);
  cover property ($rose(async_mode0_active));
  cover property (frame_sync_input);
endmodule : sbk_bank1_asserts
bind sbk_bank1_regs sbk_bank1_asserts u_chk (.*);
`default_nettype wire

// ==== verif/sbk_host_model.sv ====
// host processor model driving the serial register port
`timescale 1ns/1ps
`default_nettype none
module sbk_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_rd
);
  // idle port: strobes low, address and data parked
  initial begin
    reg_addr = 8'hA5;
    reg_wr = 1'b0;
    reg_wdata = 8'h5A;
    reg_rd = 1'b0;
  end
  // one-cycle write; parked values inverted so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // one-cycle read; data is registered, so taken a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : sbk_host_model
`default_nettype wire

// ==== verif/tb_sbk_bank1_regs.sv ====
// self-checking bench for the bank-1 configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb_sbk_bank1_regs;
  logic clk, nrst, clk_en, timestamp_capture_strobe, second_interrupt_output;
  logic shared_pin_in, ccc_enter_async0, ccc_exit_async0, ibi_request_in;
  logic ibi_payload_in, ddr_request_in, sdr_request_in;
  logic [7:0] trim_selftest_x, trim_selftest_y, trim_selftest_z, v;
  logic [19:0] timestamp_count;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, highpass_order_select, i3c_only_bus, host_spi_wire_select;
  wire [2:0] bank_select, notch_bandwidth_select, highpass_cutoff_select;
  wire [1:0] shared_pin_function;
  wire shared_pin_out, shared_pin_oe, frame_sync_input, i3c_target_active;
  wire async_mode0_active, ibi_request_out, ibi_payload_attach, ddr_accept;
  wire sdr_accept;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h456DE7B4;
  logic [7:0] mdl [256];
  logic [2:0] bank;
  logic [7:0] amap [12] = '{8'h13, 8'h5F, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64,
                            8'h7A, 8'h7B, 8'h7C, 8'h76, 8'h70};
  logic [7:0] acfg [4] = '{8'h10, 8'h90, 8'h00, 8'h1F};
  sbk_bank1_regs dut (.clk, .nrst, .clk_en, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .bank_select, .trim_selftest_x, .trim_selftest_y,
    .trim_selftest_z, .timestamp_count, .timestamp_capture_strobe,
    .notch_bandwidth_select, .highpass_cutoff_select, .highpass_order_select,
    .i3c_only_bus, .host_spi_wire_select, .shared_pin_function,
    .second_interrupt_output, .shared_pin_in, .shared_pin_out, .shared_pin_oe,
    .frame_sync_input, .ccc_enter_async0, .ccc_exit_async0, .ibi_request_in,
    .ibi_payload_in, .ddr_request_in, .sdr_request_in, .i3c_target_active,
    .async_mode0_active, .ibi_request_out, .ibi_payload_attach, .ddr_accept,
    .sdr_accept);
  sbk_host_model u_host (.clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd);
  // ========
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      close_out();
    end
  end
  // ========
  // helpers
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  // writable bits per address; zero marks read-only, unmapped or the bank select (written through its own path)
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h13: return 8'h7F;
      8'h5F, 8'h60, 8'h61: return 8'hFF;
      8'h7A: return 8'h42;
      8'h7B: return 8'h06;
      8'h7C: return 8'h9F;
      default: return 8'h00;
    endcase
  endfunction : wmask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic chk1(input string nm, input logic e, input logic s);
    chk(nm, {7'h0, e}, {7'h0, s});
  endtask : chk1
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_host.wr(a, d);
    if (a == 8'h76) bank = d[2:0];
    else if (bank == 3'h1 && wmask(a) != 8'h00) mdl[a] = d & wmask(a);
  endtask : w
  task automatic r(input logic [7:0] a);
    logic [7:0] s;
    u_host.rd(a, s);
    chk("reg_rdata", a == 8'h76 ? {5'h0, bank} : bank == 3'h1 ? mdl[a] : 8'h00, s);
  endtask : r
  // reset for 8 cycles; trims change so the preload is seen each time
  task automatic do_reset();
    trim_selftest_x = rnd();
    trim_selftest_y = rnd();
    trim_selftest_z = rnd();
    nrst = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    bank = 3'h0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[8'h13] = 8'h11 & wmask(8'h13);
    mdl[8'h7A] = 8'h03 & wmask(8'h7A);
    mdl[8'h7B] = 8'h20 & wmask(8'h7B);
    mdl[8'h7C] = 8'h5F & wmask(8'h7C);
    mdl[8'h5F] = trim_selftest_x;
    mdl[8'h60] = trim_selftest_y;
    mdl[8'h61] = trim_selftest_z;
  endtask : do_reset
  // config outputs against the model
  task automatic outs();
    logic [7:0] c;
    logic [1:0] f;
    c = mdl[8'h7C];
    f = mdl[8'h7B][2:1];
    chk("filter", mdl[8'h13], {1'b0, notch_bandwidth_select, highpass_cutoff_select,
      highpass_order_select});
    chk("bus_wire", mdl[8'h7A], {1'b0, i3c_only_bus, 4'h0, host_spi_wire_select,
      1'b0});
    chk1("target", c[4], i3c_target_active);
    chk1("ibi", c[4] & c[2] & ibi_request_in, ibi_request_out);
    chk1("payload", c[4] & c[2] & c[3] & ibi_payload_in,
      ibi_payload_attach);
    chk1("ddr", c[4] & c[1] & ddr_request_in, ddr_accept);
    chk1("sdr", c[4] & c[0] & sdr_request_in, sdr_accept);
    chk1("pin_oe", f == 2'h0, shared_pin_oe);
    chk1("pin_out", f == 2'h0 && second_interrupt_output, shared_pin_out);
    chk1("frame_sync", f == 2'h1 && shared_pin_in, frame_sync_input);
  endtask : outs
  // ========
  // main sequence, run twice so the second reset lands mid-run
  initial begin
    {clk_en, timestamp_capture_strobe, second_interrupt_output} = 3'h4;
    {shared_pin_in, ccc_enter_async0, ccc_exit_async0, ibi_request_in} = 4'h0;
    {ibi_payload_in, ddr_request_in, sdr_request_in} = 3'h4;
    timestamp_count = 20'h00000;
    for (int p = 0; p < 2; p++) begin
      do_reset();
      foreach (amap[i]) r(amap[i]);
      w(8'h76, 8'h01);
      foreach (amap[i]) r(amap[i]);
      outs();
      for (int k = 0; k < 16; k++) begin
        foreach (amap[i]) if (amap[i] != 8'h76) w(amap[i], rnd());
        w(8'h7B, {rnd() & 8'hF9} | {5'h0, k[1:0], 1'b0});
        v = rnd();
        {ibi_payload_in, ibi_request_in} = v[3:2];
        {ddr_request_in, sdr_request_in} = v[1:0];
        {second_interrupt_output, shared_pin_in} = v[5:4];
        foreach (amap[i]) r(amap[i]);
        outs();
      end
      foreach (acfg[i]) begin
        w(8'h7C, acfg[i]);
        ccc_enter_async0 = 1'b1;
        @(negedge clk);
        ccc_enter_async0 = 1'b0;
        chk1("async0", acfg[i][4] & ~acfg[i][7], async_mode0_active);
        ccc_exit_async0 = 1'b1;
        @(negedge clk);
        ccc_exit_async0 = 1'b0;
        chk1("async0", 1'b0, async_mode0_active);
      end
      repeat (4) begin
        v = rnd();
        timestamp_count = {v[3:0], rnd(), rnd()};
        timestamp_capture_strobe = 1'b1;
        @(negedge clk);
        timestamp_capture_strobe = 1'b0;
        {mdl[8'h64], mdl[8'h63], mdl[8'h62]} = {4'h0, timestamp_count};
        timestamp_count = ~timestamp_count;
        w(8'h64, rnd());
        r(8'h62);
        r(8'h63);
        r(8'h64);
      end
      // a frozen clock enable must swallow the write
      clk_en = 1'b0;
      u_host.wr(8'h13, 8'h00);
      clk_en = 1'b1;
      r(8'h13);
      w(8'h76, 8'h00);
      r(8'h13);
    end
    close_out();
  end
  task automatic close_out();
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
endmodule : tb_sbk_bank1_regs
`default_nettype wire
